// ===== rtl/sss_consts.svh
// Constants of the speed setpoint selector: register offsets, field positions,
// reset values and timing counts.
// Assumes inclusion by bare name from the package and from the ramp and selector modules.
`ifndef SSS_CONSTS_SVH
`define SSS_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define SSS_OFS_CTRL      8'h00
`define SSS_OFS_ASSIGN    8'h04
`define SSS_OFS_MIN_SP    8'h08
`define SSS_OFS_DEF_SP    8'h0c
`define SSS_OFS_MAX_SP    8'h10
`define SSS_OFS_UP_RATE   8'h14
`define SSS_OFS_DN_RATE   8'h18
`define SSS_OFS_STATUS    8'h1c
`define SSS_OFS_SETPOINT  8'h20
`define SSS_OFS_IRQ_STAT  8'h24
`define SSS_OFS_IRQ_CLR   8'h28
`define SSS_OFS_IRQ_EN    8'h2c
`define SSS_OFS_TABLE     8'h40
`define SSS_TABLE_MASK    8'hc0

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SSS_CTRL_SRC_LSB    0
`define SSS_CTRL_STEPS_LSB  2
`define SSS_CTRL_FB_BIT     4
`define SSS_ST_STEP_LSB     0
`define SSS_ST_BITS_LSB     4
`define SSS_ST_CHG_BIT      8
`define SSS_ST_AN1F_BIT     9
`define SSS_ST_AN2F_BIT     10
`define SSS_ST_SRC_LSB      11
`define SSS_IRQ_STEP_BIT    0
`define SSS_IRQ_FAIL_BIT    1
`define SSS_IRQ_CHG_BIT     2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SSS_RST_ASSIGN   8'he4
`define SSS_RST_MIN_SP   16'h0000
`define SSS_RST_DEF_SP   16'h0000
`define SSS_RST_MAX_SP   16'hffff
`define SSS_RST_RATE     16'h0001

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SSS_CLK_PERIOD_NS   25
`define SSS_RAMP_TICK_NS    1000000
`define SSS_RAMP_TICK_CYC   (`SSS_RAMP_TICK_NS / `SSS_CLK_PERIOD_NS)

`endif

// ===== rtl/sss_pkg.sv
// Types of the speed setpoint selector.
// Assumes the constants header is on the include path.
`include "sss_consts.svh"

package sss_pkg;

   typedef enum logic [1:0] {
      SSS_SRC_STEP,
      SSS_SRC_ANALOG,
      SSS_SRC_POT,
      SSS_SRC_RSVD
   } sss_src_t;

   typedef enum logic [1:0] {
      SSS_STEPS_16,
      SSS_STEPS_8,
      SSS_STEPS_4,
      SSS_STEPS_RSVD
   } sss_steps_t;

   typedef struct packed {
      sss_src_t src;
      sss_steps_t steps;
      logic fb_default;
      logic [3:0][1:0] assign_sel;
      logic [15:0] min_sp;
      logic [15:0] def_sp;
      logic [15:0] max_sp;
      logic [15:0] up_rate;
      logic [15:0] dn_rate;
      logic [15:0][15:0] speed_tab;
      logic [3:0] step;
      logic [3:0] step_bits;
      logic chg;
      logic fail;
      logic [15:0] setpoint;
      logic [2:0] irq_stat;
      logic [2:0] irq_en;
      logic [31:0] rdata;
   } sss_top_state_t;

   typedef struct packed {
      logic [31:0] tick_cnt;
      logic [15:0] value;
   } sss_ramp_state_t;

endpackage : sss_pkg

// ===== rtl/sss_ramp.sv
// Digital potentiometer: up/down keys ramp a setpoint at programmable rates.
// Assumes key levels are already synchronised and min does not exceed max.
`include "sss_consts.svh"
module sss_ramp
   import sss_pkg::*;
#(
   parameter int TICK_CYC = `SSS_RAMP_TICK_CYC
) (
   input wire logic CLK,               // System clock
   input wire logic RST_N,             // Synchronous reset, active low
   input wire logic EN,                // Ramp active
   input wire logic UP,                // Increase key level
   input wire logic DN,                // Decrease key level
   input wire logic [15:0] UP_RATE,    // Increment per tick
   input wire logic [15:0] DN_RATE,    // Decrement per tick
   input wire logic [15:0] MIN_SP,     // Lower clamp
   input wire logic [15:0] MAX_SP,     // Upper clamp
   output logic [15:0] VALUE           // Ramped setpoint
);

   sss_ramp_state_t q, d;
   logic tick;
   logic [16:0] sum;

   assign tick = (q.tick_cnt == 32'(TICK_CYC - 1));

   always_comb begin
      d = q;
      sum = '0;
      d.tick_cnt = tick ? '0 : q.tick_cnt + 32'h1;
      // Both keys at once cancel rather than fight
      if (EN && tick && UP && !DN) begin                                    // RL10
         sum = {1'b0, q.value} + {1'b0, UP_RATE};
         d.value = (sum > {1'b0, MAX_SP}) ? MAX_SP : sum[15:0];
      end else if (EN && tick && DN && !UP) begin                           // RL10
         // Widened so a limit near full scale cannot wrap the floor test
         d.value = ({1'b0, q.value} < {1'b0, MIN_SP} + {1'b0, DN_RATE}) ?
                   MIN_SP : q.value - DN_RATE;
      end
      // Keeps the value inside the window after software moves the limits
      if (d.value < MIN_SP) begin
         d.value = MIN_SP;
      end else if (d.value > MAX_SP) begin
         d.value = MAX_SP;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign VALUE = q.value;

endmodule : sss_ramp

// ===== rtl/sss_selector.sv
// Speed setpoint selector: step switches, analogue adjusters or a digital
// potentiometer produce the governor speed setpoint.
// Assumes a plain register port driven by a master on the same clock, analogue
// words already converted and synchronous, switches and keys asynchronous.
//
// Behaviour
// (RL1) Source register picks steps, analogue, potentiometer
// (RL2) Four switches decode binary step, bit3 MSB
// (RL3) Decoded step number readable as status
// (RL4) Each step switch state readable separately
// (RL5) Four inputs each assignable to step bit
// (RL6) Sixteen-entry speed table indexed by step
// (RL7) Eight or four step modes mask bits
// (RL8) Changeover selects analogue second setpoint
// (RL9) Failed analogue replaced by minimum or default
// (RL10) Keys ramp setpoint up/down at rates
// (RL11) Switches and keys pass two-flop synchroniser
`include "sss_consts.svh"
module sss_selector
   import sss_pkg::*;
#(
   parameter int RAMP_TICK_CYC = `SSS_RAMP_TICK_CYC
) (
   input wire logic CORE_CLK,          // System clock, 40 MHz
   input wire logic RST_N,             // Synchronous reset, active low
   input wire logic [7:0] ADDR,        // Register byte address
   input wire logic [31:0] WDATA,      // Register write data
   input wire logic WR_STB,            // Write strobe
   input wire logic RD_STB,            // Read strobe
   output logic [31:0] RDATA,          // Read data, cycle after strobe
   input wire logic [3:0] SW_IN,       // Raw switch inputs
   input wire logic KEY_UP,            // Raw increase key
   input wire logic KEY_DN,            // Raw decrease key
   input wire logic SETP2_SEL,         // Raw changeover switch
   input wire logic [15:0] AN1_VALUE,  // First analogue setpoint
   input wire logic AN1_FAIL,          // First analogue signal lost
   input wire logic [15:0] AN2_VALUE,  // Second analogue setpoint
   input wire logic AN2_FAIL,          // Second analogue signal lost
   output logic [15:0] SETPOINT,       // Selected speed setpoint
   output logic [3:0] STEP,            // Decoded speed step
   output logic IRQ                    // Level interrupt
);

   // -------------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------------
   function automatic logic is_table(input logic [7:0] a);
      return (a & `SSS_TABLE_MASK) == `SSS_OFS_TABLE && a[1:0] == 2'b00;
   endfunction : is_table

   function automatic logic [15:0] fallback(input logic [15:0] v, input logic failed,
                                            input logic use_def, input logic [15:0] mn,
                                            input logic [15:0] df);
      if (!failed) begin
         return v;
      end
      return use_def ? df : mn;
   endfunction : fallback

   // -------------------------------------------------------------------------
   // Input synchronisation
   // -------------------------------------------------------------------------
   logic [6:0] sync_out;
   logic [3:0] sw_s;
   logic up_s;
   logic dn_s;
   logic chg_s;

   sss_sync #(
      .WIDTH(7)
   ) u_sync (
      .CLK(CORE_CLK),
      .RST_N(RST_N),
      .D({SETP2_SEL, KEY_DN, KEY_UP, SW_IN}),                              // RL11
      .Q(sync_out)
   );

   assign sw_s = sync_out[3:0];
   assign up_s = sync_out[4];
   assign dn_s = sync_out[5];
   assign chg_s = sync_out[6];

   // -------------------------------------------------------------------------
   // Digital potentiometer
   // -------------------------------------------------------------------------
   sss_top_state_t q, d;
   logic [15:0] pot_value;

   sss_ramp #(
      .TICK_CYC(RAMP_TICK_CYC)
   ) u_ramp (
      .CLK(CORE_CLK),
      .RST_N(RST_N),
      .EN(q.src == SSS_SRC_POT && !q.chg),
      .UP(up_s),
      .DN(dn_s),
      .UP_RATE(q.up_rate),
      .DN_RATE(q.dn_rate),
      .MIN_SP(q.min_sp),
      .MAX_SP(q.max_sp),
      .VALUE(pot_value)
   );

   // -------------------------------------------------------------------------
   // Next-state logic
   // -------------------------------------------------------------------------
   logic [3:0] bits;
   logic [3:0] step_n;
   logic [15:0] sp1;
   logic [15:0] sp_n;
   logic fail_n;
   logic [2:0] ev;
   logic [31:0] status;

   always_comb begin
      d = q;
      bits = '0;
      step_n = '0;
      sp1 = '0;
      sp_n = '0;
      fail_n = 1'b0;
      ev = '0;
      status = '0;

      // Each step bit reads the input that software assigned to it
      for (int k = 0; k < 4; k++) begin
         bits[k] = sw_s[q.assign_sel[k]];                                   // RL5
      end
      d.step_bits = bits;                                                   // RL4

      // Unused upper switches are ignored in the reduced step modes
      unique case (q.steps)
         SSS_STEPS_8: step_n = {1'b0, bits[2:0]};                           // RL7
         SSS_STEPS_4: step_n = {2'b00, bits[1:0]};                          // RL7
         default: step_n = bits;                                            // RL2
      endcase
      d.step = step_n;                                                      // RL3
      d.chg = chg_s;

      // First setpoint source
      unique case (q.src)
         SSS_SRC_ANALOG: begin
            sp1 = fallback(AN1_VALUE, AN1_FAIL, q.fb_default,
                           q.min_sp, q.def_sp);                             // RL9
         end
         SSS_SRC_POT: sp1 = pot_value;                                      // RL10
         default: sp1 = q.speed_tab[q.step];                                // RL1 RL6
      endcase

      // Changeover forces the analogue second setpoint
      if (q.chg) begin
         sp_n = fallback(AN2_VALUE, AN2_FAIL, q.fb_default,
                         q.min_sp, q.def_sp);                               // RL8 RL9
         fail_n = AN2_FAIL;
      end else begin
         sp_n = sp1;
         fail_n = (q.src == SSS_SRC_ANALOG) && AN1_FAIL;
      end
      d.setpoint = sp_n;
      d.fail = fail_n;

      // Events: step change, failure of the active analogue, changeover
      ev[`SSS_IRQ_STEP_BIT] = (step_n != q.step);
      ev[`SSS_IRQ_FAIL_BIT] = fail_n && !q.fail;
      ev[`SSS_IRQ_CHG_BIT] = (chg_s != q.chg);

      // Register writes
      if (WR_STB) begin
         if (is_table(ADDR)) begin
            d.speed_tab[ADDR[5:2]] = WDATA[15:0];                           // RL6
         end else begin
            unique case (ADDR)
               `SSS_OFS_CTRL: begin
                  d.src = sss_src_t'(WDATA[`SSS_CTRL_SRC_LSB +: 2]);        // RL1
                  d.steps = sss_steps_t'(WDATA[`SSS_CTRL_STEPS_LSB +: 2]);
                  d.fb_default = WDATA[`SSS_CTRL_FB_BIT];
               end
               `SSS_OFS_ASSIGN: d.assign_sel = WDATA[7:0];                  // RL5
               `SSS_OFS_MIN_SP: d.min_sp = WDATA[15:0];
               `SSS_OFS_DEF_SP: d.def_sp = WDATA[15:0];
               `SSS_OFS_MAX_SP: d.max_sp = WDATA[15:0];
               `SSS_OFS_UP_RATE: d.up_rate = WDATA[15:0];
               `SSS_OFS_DN_RATE: d.dn_rate = WDATA[15:0];
               `SSS_OFS_IRQ_CLR: d.irq_stat = q.irq_stat & ~WDATA[2:0];
               `SSS_OFS_IRQ_EN: d.irq_en = WDATA[2:0];
               default: ;
            endcase
         end
      end
      // Set after clear so a simultaneous event is never lost
      d.irq_stat = d.irq_stat | ev;

      // Status word
      status[`SSS_ST_STEP_LSB +: 4] = q.step;                               // RL3
      status[`SSS_ST_BITS_LSB +: 4] = q.step_bits;                          // RL4
      status[`SSS_ST_CHG_BIT] = q.chg;
      status[`SSS_ST_AN1F_BIT] = AN1_FAIL;
      status[`SSS_ST_AN2F_BIT] = AN2_FAIL;
      status[`SSS_ST_SRC_LSB +: 2] = q.src;

      // Register reads: data only in the cycle after the strobe
      d.rdata = '0;
      if (RD_STB) begin
         if (is_table(ADDR)) begin
            d.rdata = {16'h0000, q.speed_tab[ADDR[5:2]]};
         end else begin
            unique case (ADDR)
               `SSS_OFS_CTRL: begin
                  d.rdata[`SSS_CTRL_SRC_LSB +: 2] = q.src;
                  d.rdata[`SSS_CTRL_STEPS_LSB +: 2] = q.steps;
                  d.rdata[`SSS_CTRL_FB_BIT] = q.fb_default;
               end
               `SSS_OFS_ASSIGN: d.rdata = {24'h000000, q.assign_sel};
               `SSS_OFS_MIN_SP: d.rdata = {16'h0000, q.min_sp};
               `SSS_OFS_DEF_SP: d.rdata = {16'h0000, q.def_sp};
               `SSS_OFS_MAX_SP: d.rdata = {16'h0000, q.max_sp};
               `SSS_OFS_UP_RATE: d.rdata = {16'h0000, q.up_rate};
               `SSS_OFS_DN_RATE: d.rdata = {16'h0000, q.dn_rate};
               `SSS_OFS_STATUS: d.rdata = status;
               `SSS_OFS_SETPOINT: d.rdata = {16'h0000, q.setpoint};
               `SSS_OFS_IRQ_STAT: d.rdata = {29'h00000000, q.irq_stat};
               `SSS_OFS_IRQ_EN: d.rdata = {29'h00000000, q.irq_en};
               default: d.rdata = '0;
            endcase
         end
      end
   end

   // -------------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------------
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         q <= '0;
         q.assign_sel <= `SSS_RST_ASSIGN;
         q.min_sp <= `SSS_RST_MIN_SP;
         q.def_sp <= `SSS_RST_DEF_SP;
         q.max_sp <= `SSS_RST_MAX_SP;
         q.up_rate <= `SSS_RST_RATE;
         q.dn_rate <= `SSS_RST_RATE;
      end else begin
         q <= d;
      end
   end

   assign RDATA = q.rdata;
   assign SETPOINT = q.setpoint;
   assign STEP = q.step;
   assign IRQ = |(q.irq_stat & q.irq_en);

endmodule : sss_selector

// ===== rtl/sss_sync.sv
// Two-stage synchroniser for a group of asynchronous levels.
// Assumes each bit is an independent level; no bus coherency is implied.
module sss_sync
   import sss_pkg::*;
#(
   parameter int WIDTH = 7
) (
   input wire logic CLK,               // System clock
   input wire logic RST_N,             // Synchronous reset, active low
   input wire logic [WIDTH-1:0] D,     // Asynchronous levels
   output logic [WIDTH-1:0] Q          // Synchronised levels
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } sss_sync_state_t;

   sss_sync_state_t q, d;

   // First stage feeds only the second stage
   always_comb begin
      d = q;
      d.s1 = D;
      d.s2 = q.s1;
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign Q = q.s2;

endmodule : sss_sync

// ===== verification/sss_checker.sv
// Concurrent checks of the speed setpoint selector at its top ports.
// Assumes configuration changes only by writes on the register port.
module sss_checker
   import sss_pkg::*;
(
   input wire logic CORE_CLK, // Clock
   input wire logic RST_N, // Reset
   input wire logic [7:0] ADDR, // Address
   input wire logic [31:0] WDATA, // Write data
   input wire logic WR_STB, // Write strobe
   input wire logic RD_STB, // Read strobe
   input wire logic [31:0] RDATA, // Read data
   input wire logic [3:0] SW_IN, // Switches
   input wire logic KEY_UP, // Up key
   input wire logic KEY_DN, // Down key
   input wire logic SETP2_SEL, // Changeover
   input wire logic [15:0] AN1_VALUE, // Adjuster 1
   input wire logic AN1_FAIL, // Adjuster 1 lost
   input wire logic [15:0] AN2_VALUE, // Adjuster 2
   input wire logic AN2_FAIL, // Adjuster 2 lost
   input wire logic [15:0] SETPOINT, // Setpoint
   input wire logic [3:0] STEP, // Step
   input wire logic IRQ // Interrupt
);
   // ------------------------------------------------------------------
   // Shadow of the configuration
   // ------------------------------------------------------------------
   logic [1:0] src_q, steps_q;
   logic fb_q;
   logic [7:0] asg_q;
   logic [15:0] min_q, def_q, max_q;
   logic [2:0] en_q;
   logic [3:0] wr_cnt, chg_cnt;

   function automatic logic [3:0] dec_step(input logic [3:0] s, input logic [7:0] a,
                                           input logic [1:0] m);
      logic [3:0] r;
      for (int k = 0; k < 4; k++)
         r[k] = s[a[2*k+:2]];
      if (m == 2'h1) r[3] = 1'b0;
      if (m == 2'h2) r[3:2] = 2'h0;
      return r;
   endfunction : dec_step

   // Counters only open a check once all latencies have surely passed
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         {fb_q, steps_q, src_q} <= 5'h00;
         asg_q <= 8'he4;
         min_q <= 16'h0000;
         def_q <= 16'h0000;
         max_q <= 16'hffff;
         en_q <= 3'h0;
         wr_cnt <= 4'h0;
         chg_cnt <= 4'h0;
      end else begin
         wr_cnt <= WR_STB ? 4'h0 : wr_cnt + {3'h0, wr_cnt != 4'hf};
         if (SETP2_SEL && $stable(AN2_VALUE) && $stable(AN2_FAIL) && !WR_STB)
            chg_cnt <= chg_cnt + {3'h0, chg_cnt != 4'hf};
         else
            chg_cnt <= 4'h0;
         if (WR_STB) begin
            case (ADDR)
               8'h00: {fb_q, steps_q, src_q} <= WDATA[4:0];
               8'h04: asg_q <= WDATA[7:0];
               8'h08: min_q <= WDATA[15:0];
               8'h0c: def_q <= WDATA[15:0];
               8'h10: max_q <= WDATA[15:0];
               8'h2c: en_q <= WDATA[2:0];
               default: ;
            endcase
         end
      end
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);

   rdata_idle_a: assert property (!$past(RD_STB) |-> RDATA == 32'h0)
      else $error("read data outside answer cycle");
   rd_zero_a: assert property ($past(RD_STB) && $past(ADDR) == 8'h30 |-> RDATA == 32'h0)
      else $error("unmapped read not zero");
   step_follow_a: assert property (wr_cnt >= 4'h4 |->
      STEP == dec_step($past(SW_IN, 3), asg_q, steps_q))
      else $error("step not decoded from synchronised switches");
   // Setpoint lags the adjuster by one register stage
   chg_an2_a: assert property (chg_cnt >= 4'h6 && !$past(AN2_FAIL) |->
      SETPOINT == $past(AN2_VALUE))
      else $error("changeover does not select adjuster 2");
   chg_fb_a: assert property (chg_cnt >= 4'h6 && $past(AN2_FAIL) |->
      SETPOINT == (fb_q ? def_q : min_q))
      else $error("failed adjuster not replaced");
   pot_clamp_a: assert property ((!SETP2_SEL)[*6] ##0 (src_q == 2'h2 && wr_cnt == 4'hf)
      |-> SETPOINT <= max_q && SETPOINT >= min_q)
      else $error("ramp value outside limits");
   irq_mask_a: assert property (en_q == 3'h0 && $past(en_q) == 3'h0 |-> !IRQ)
      else $error("interrupt while all masked");
   irq_step_a: assert property ($changed(STEP) && en_q[0] |-> ##[0:2] IRQ)
      else $error("step change raised no interrupt");
endmodule : sss_checker

// ===== verification/sss_operator.sv
// Operator side: step switches, keys, changeover and two adjusters.
// Assumes commands from the bench; a lost adjuster shows an inverted word.
module sss_operator (
   input wire logic clk, // Clock
   input wire logic [3:0] sw_c, // Switch command
   input wire logic [1:0] key_c, // Up, down command
   input wire logic sel_c, // Changeover command
   input wire logic [31:0] an_c, // Adjuster 2, 1 words
   input wire logic [1:0] anf_c, // Adjuster 2, 1 lost
   output logic [3:0] sw = 4'h0, // Switches
   output logic [1:0] key = 2'h0, // Keys
   output logic sel = 1'b0, // Changeover
   output logic [31:0] an = 32'h0, // Adjuster words
   output logic [1:0] anf = 2'h0 // Adjuster lost
);
   // A lost line never keeps its last good word
   always @(posedge clk) begin
      sw <= sw_c;
      key <= key_c;
      sel <= sel_c;
      anf <= anf_c;
      an[15:0] <= anf_c[0] ? ~an_c[15:0] : an_c[15:0];
      an[31:16] <= anf_c[1] ? ~an_c[31:16] : an_c[31:16];
   end
endmodule : sss_operator

// ===== verification/test_speed_setpoint_selector.sv
// Self-checking bench of the speed setpoint selector with an operator model.
// Assumes the checker is bound to the top design module below.
module test_speed_setpoint_selector;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata, rv, an;
   logic [15:0] setpoint, mn, df, v;
   logic [3:0] step, sw, sv;
   logic irq, sel;
   logic [1:0] key, anf;
   logic [3:0] sw_c = 4'h0;
   logic [1:0] key_c = 2'h0;
   logic sel_c = 1'b0;
   logic [31:0] an_c = 32'h0;
   logic [1:0] anf_c = 2'h0;
   logic [15:0] tab [16];
   integer seed = 32'hfb29;
   int miscompares = 0;
   int n_checks = 0;

   sss_operator op (.clk(clk), .sw_c(sw_c), .key_c(key_c), .sel_c(sel_c), .an_c(an_c),
      .anf_c(anf_c), .sw(sw), .key(key), .sel(sel), .an(an), .anf(anf));
   sss_selector #(.RAMP_TICK_CYC(4)) dut (.CORE_CLK(clk), .RST_N(rst_n), .ADDR(addr),
      .WDATA(wdata), .WR_STB(wr), .RD_STB(rd), .RDATA(rdata), .SW_IN(sw), .KEY_UP(key[1]),
      .KEY_DN(key[0]), .SETP2_SEL(sel), .AN1_VALUE(an[15:0]), .AN1_FAIL(anf[0]),
      .AN2_VALUE(an[31:16]), .AN2_FAIL(anf[1]), .SETPOINT(setpoint), .STEP(step), .IRQ(irq));

   always #12.5 clk = ~clk;

   // ------------------------------------------------------------------
   // Bus, wait and compare helpers
   // ------------------------------------------------------------------
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd_reg

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %h, expected %h", $time, got, exp);
      end
   endtask : check

   task automatic give_verdict();
      if (miscompares == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : give_verdict

   function automatic logic [3:0] exp_step(input logic [3:0] s, input logic [7:0] a,
                                           input logic [1:0] m);
      logic [3:0] r;
      for (int k = 0; k < 4; k++)
         r[k] = s[a[2*k+:2]];
      if (m == 2'h1) r[3] = 1'b0;
      if (m == 2'h2) r[3:2] = 2'h0;
      return r;
   endfunction : exp_step

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rd_reg(8'h04, rv);
      check(rv, 32'he4);
      rd_reg(8'h30, rv);
      check(rv, 32'h0);
      for (int i = 0; i < 16; i++) begin
         tab[i] = 16'($random(seed));
         wr_reg(8'h40 + 8'(4 * i), {16'h0, tab[i]});
      end
      rd_reg(8'h7c, rv);
      check(rv, {16'h0, tab[15]});
      for (int i = 0; i < 16; i++) begin
         @(posedge clk);
         sw_c <= 4'(i);
         cyc(6);
         check(step, i);
         check(setpoint, tab[i]);
         rd_reg(8'h1c, rv);
         check(rv[7:0], {4'(i), 4'(i)});
      end
      for (int m = 1; m < 3; m++) begin
         wr_reg(8'h00, 32'(m) << 2);
         @(posedge clk);
         sw_c <= 4'($random(seed));
         cyc(6);
         sv = exp_step(sw_c, 8'he4, 2'(m));
         check(step, sv);
         check(setpoint, tab[sv]);
      end
      wr_reg(8'h00, 32'h0);
      wr_reg(8'h04, 32'h1b);
      @(posedge clk);
      sw_c <= 4'($random(seed));
      cyc(6);
      check(step, exp_step(sw_c, 8'h1b, 2'h0));
      wr_reg(8'h04, 32'he4);
      // Interrupt: raise, mask, clear
      wr_reg(8'h28, 32'h7);
      wr_reg(8'h2c, 32'h1);
      cyc(1);
      check(irq, 1'b0);
      @(posedge clk);
      sw_c <= ~sw_c;
      cyc(6);
      check(irq, 1'b1);
      wr_reg(8'h2c, 32'h0);
      cyc(1);
      check(irq, 1'b0);
      wr_reg(8'h28, 32'h1);
      wr_reg(8'h2c, 32'h1);
      cyc(1);
      check(irq, 1'b0);
      // Adjusters, loss and changeover
      mn = 16'($random(seed)) & 16'h03ff;
      df = 16'($random(seed));
      wr_reg(8'h08, {16'h0, mn});
      wr_reg(8'h0c, {16'h0, df});
      wr_reg(8'h00, 32'h1);
      @(posedge clk);
      an_c <= $random(seed);
      cyc(6);
      check(setpoint, an_c[15:0]);
      @(posedge clk);
      anf_c <= 2'h1;
      cyc(6);
      check(setpoint, mn);
      wr_reg(8'h00, 32'h11);
      cyc(2);
      check(setpoint, df);
      @(posedge clk);
      sel_c <= 1'b1;
      cyc(8);
      check(setpoint, an_c[31:16]);
      @(posedge clk);
      anf_c <= 2'h2;
      cyc(6);
      check(setpoint, df);
      rd_reg(8'h1c, rv);
      check(rv[12:8], 5'h0d);
      rd_reg(8'h24, rv);
      check(rv, 32'h6);
      // Digital potentiometer
      @(posedge clk);
      sel_c <= 1'b0;
      anf_c <= 2'h0;
      wr_reg(8'h10, 32'h0800);
      wr_reg(8'h14, 32'h0100);
      wr_reg(8'h18, 32'h0200);
      wr_reg(8'h00, 32'h2);
      cyc(8);
      check(setpoint, mn);
      @(posedge clk);
      key_c <= 2'h2;
      cyc(10);
      check((setpoint - mn) & 16'h00ff, 16'h0);
      check(setpoint > mn, 1'b1);
      @(posedge clk);
      key_c <= 2'h3;
      cyc(4);
      v = setpoint;
      cyc(20);
      check(setpoint, v);
      @(posedge clk);
      key_c <= 2'h2;
      cyc(50);
      check(setpoint, 16'h0800);
      @(posedge clk);
      key_c <= 2'h1;
      cyc(60);
      check(setpoint, mn);
      // Reset in mid-run
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      cyc(2);
      check(setpoint, 16'h0);
      check(irq, 1'b0);
      give_verdict();
   end

   initial begin
      #200us;
      miscompares++;
      give_verdict();
   end
endmodule : test_speed_setpoint_selector

bind sss_selector sss_checker chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .ADDR(ADDR),
   .WDATA(WDATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA), .SW_IN(SW_IN),
   .KEY_UP(KEY_UP), .KEY_DN(KEY_DN), .SETP2_SEL(SETP2_SEL), .AN1_VALUE(AN1_VALUE),
   .AN1_FAIL(AN1_FAIL), .AN2_VALUE(AN2_VALUE), .AN2_FAIL(AN2_FAIL),
   .SETPOINT(SETPOINT), .STEP(STEP), .IRQ(IRQ));
